// [hdl/fscr_pkg.sv]
package fscr_pkg;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_RSVD_LO = 8'h09;
  localparam logic [7:0] ADDR_RSVD_HI = 8'h0F;
  localparam logic [7:0] ADDR_CLIP_MID = 8'h10;
  localparam logic [7:0] ADDR_CLIP_LOW = 8'h11;
  localparam int OCSEL_LSB = 4;
  localparam int CLKF_BIT = 3;
  localparam int OCF_BIT = 2;
  localparam int DCF_BIT = 1;
  localparam int OTF_BIT = 0;
  localparam int CLIP_LOW_LSB = 2;
  localparam logic [1:0] OCSEL_RST = 2'h0;
  localparam logic [7:0] CLIP_MID_RST = 8'hFF;
  localparam logic [5:0] CLIP_LOW_RST = 6'h3F;
  localparam logic [1:0] CLIP_RSVD_RST = 2'h0;
  localparam logic [5:0] CLIP_HIGH_RST = 6'h3F;
  localparam logic [1:0] OCSEL_FULL = 2'h0;
  localparam logic [1:0] OCSEL_3Q = 2'h1;
  localparam logic [1:0] OCSEL_HALF = 2'h2;
  localparam logic [1:0] OCSEL_1Q = 2'h3;

  typedef struct packed {
    logic clock_bad;
    logic overtemp;
    logic dc_over;
    logic [15:0] current;
  } fscr_sense_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fscr_req_t;
endpackage : fscr_pkg

// [hdl/fscr_clipper.sv]
module fscr_clipper (
  input wire logic signed [19:0] sample_in,
  input wire logic [19:0] clip_threshold,
  output logic signed [19:0] sample_out
);
  logic [19:0] lim_mag;
  logic signed [20:0] pos_lim;
  logic signed [20:0] neg_lim;
  logic signed [20:0] samp_ext;

  always_comb
  begin
    // capping first keeps the negative limit inside the sample range
    lim_mag = (clip_threshold > 20'h7FFFF) ? 20'h7FFFF : clip_threshold;
    pos_lim = {1'b0, lim_mag};
    neg_lim = -pos_lim;
    samp_ext = {sample_in[19], sample_in};
    if (samp_ext > pos_lim)
    begin
      sample_out = pos_lim[19:0]; // [R12]
    end
    else if (samp_ext < neg_lim)
    begin
      sample_out = neg_lim[19:0]; // [R12]
    end
    else
    begin
      sample_out = sample_in;
    end
  end
endmodule : fscr_clipper

// [hdl/fscr_regs.sv]
// Function
// [R01] a two-bit field selects the overcurrent limit: 00 full (reset), 01 3/4, 10 1/2, 11 1/4.
// [R02] status bit 3 reads high while a clock fault is present and low otherwise.
// [R03] the clock fault never latches and clears itself when the clocks recover.
// [R04] an overcurrent sets bit 2, which holds and halts the amplifier until shutdown toggles.
// [R05] a dc offset fault sets bit 1, which holds and halts the amplifier until shutdown toggles.
// [R06] an overtemperature sets bit 0, which holds until shutdown toggles.
// [R07] bits 7:6 of the fault register are read-only zero and the host leaves them alone.
// [R08] the 20-bit clip threshold takes bits 13:6 from the full byte at 0x10.
// [R09] the register at 0x11 holds threshold bits 5:0 in its bits 7:2, read and write.
// [R10] the host keeps bits 1:0 of 0x11 at zero.
// [R11] the host does not touch the reserved addresses 0x09 to 0x0F.
// [R12] each sample is limited in magnitude to the 20-bit clip threshold.
// [R13] a low-then-high edge on shutdown clears the latched faults and restarts operation.
module fscr_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fscr_pkg::fscr_req_t req,
  output logic [7:0] rdata,
  input wire fscr_pkg::fscr_sense_t sense,
  input wire logic [15:0] overcurrent_nominal,
  input wire logic speaker_shutdown_n,
  input wire logic signed [19:0] sample_in,
  output logic signed [19:0] sample_out,
  output logic amp_run,
  output logic clock_fault_flag,
  output logic overcurrent_fault_flag,
  output logic dc_offset_fault_flag,
  output logic overtemp_fault_flag
);
  typedef enum logic [2:0] {
    FSCR_SHUT = 3'b001,
    FSCR_RUN = 3'b010,
    FSCR_HALT = 3'b100
  } fscr_state_t;

  fscr_state_t state_ff, nxt_state;
  logic [1:0] ocsel_ff, nxt_ocsel;
  logic [7:0] clip_mid_ff, nxt_clip_mid;
  logic [7:0] clip_low_ff, nxt_clip_low;
  logic ocf_ff, nxt_ocf;
  logic dcf_ff, nxt_dcf;
  logic otf_ff, nxt_otf;
  logic clkf_ff, nxt_clkf;
  logic sd_prev_ff, nxt_sd_prev;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [15:0] oc_limit;
  logic oc_trip;
  logic sd_rise;
  logic [19:0] clip_threshold;
  logic signed [19:0] clipped;

  always_comb
  begin
    case (ocsel_ff) // [R01]
      fscr_pkg::OCSEL_3Q: oc_limit = 16'((18'(overcurrent_nominal) * 18'h3) >> 2);
      fscr_pkg::OCSEL_HALF: oc_limit = overcurrent_nominal >> 1;
      fscr_pkg::OCSEL_1Q: oc_limit = overcurrent_nominal >> 2;
      default: oc_limit = overcurrent_nominal;
    endcase
  end

  assign oc_trip = sense.current > oc_limit;
  assign sd_rise = speaker_shutdown_n & ~sd_prev_ff; // [R13]
  assign clip_threshold = {fscr_pkg::CLIP_HIGH_RST, clip_mid_ff,
    clip_low_ff[7:fscr_pkg::CLIP_LOW_LSB]}; // [R08] [R09]

  fscr_clipper u_clip (
    .sample_in(sample_in),
    .clip_threshold(clip_threshold),
    .sample_out(clipped)
  );

  // host-writable configuration
  always_comb
  begin
    nxt_ocsel = ocsel_ff;
    nxt_clip_mid = clip_mid_ff;
    nxt_clip_low = clip_low_ff;
    if (req.wr_en)
    begin
      case (req.addr)
        fscr_pkg::ADDR_FAULT: nxt_ocsel = req.wdata[fscr_pkg::OCSEL_LSB +: 2]; // [R07]
        fscr_pkg::ADDR_CLIP_MID: nxt_clip_mid = req.wdata; // [R08]
        fscr_pkg::ADDR_CLIP_LOW: nxt_clip_low = req.wdata; // [R09]
        default: nxt_clip_low = clip_low_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ocsel_ff <= fscr_pkg::OCSEL_RST;
      clip_mid_ff <= fscr_pkg::CLIP_MID_RST;
      clip_low_ff <= {fscr_pkg::CLIP_LOW_RST, fscr_pkg::CLIP_RSVD_RST};
    end
    else
    begin
      ocsel_ff <= nxt_ocsel;
      clip_mid_ff <= nxt_clip_mid;
      clip_low_ff <= nxt_clip_low;
    end
  end

  // fault status; a new overtemperature wins over a clear in the same cycle
  always_comb
  begin
    nxt_sd_prev = speaker_shutdown_n;
    nxt_clkf = sense.clock_bad; // [R02] [R03]
    nxt_ocf = ocf_ff;
    nxt_dcf = dcf_ff;
    nxt_otf = otf_ff;
    if (sd_rise)
    begin
      nxt_ocf = 1'b0; // [R13]
      nxt_dcf = 1'b0;
      nxt_otf = 1'b0;
    end
    if (state_ff != FSCR_SHUT && oc_trip)
    begin
      nxt_ocf = 1'b1; // [R04]
    end
    if (state_ff != FSCR_SHUT && sense.dc_over)
    begin
      nxt_dcf = 1'b1; // [R05]
    end
    if (sense.overtemp)
    begin
      nxt_otf = 1'b1; // [R06]
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ocf_ff <= 1'b0;
      dcf_ff <= 1'b0;
      otf_ff <= 1'b0;
      clkf_ff <= 1'b0;
      sd_prev_ff <= 1'b0;
    end
    else
    begin
      ocf_ff <= nxt_ocf;
      dcf_ff <= nxt_dcf;
      otf_ff <= nxt_otf;
      clkf_ff <= nxt_clkf;
      sd_prev_ff <= nxt_sd_prev;
    end
  end

  // read data holds until the next read
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (req.rd_en)
    begin
      case (req.addr)
        fscr_pkg::ADDR_FAULT: nxt_rdata = {2'h0, ocsel_ff, clkf_ff, ocf_ff, dcf_ff, otf_ff}; // [R07]
        fscr_pkg::ADDR_CLIP_MID: nxt_rdata = clip_mid_ff;
        fscr_pkg::ADDR_CLIP_LOW: nxt_rdata = clip_low_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FSCR_SHUT:
      begin
        // an overtemperature still present at restart keeps the amplifier halted
        if (sd_rise && nxt_otf)
        begin
          nxt_state = FSCR_HALT; // [R06]
        end
        else if (sd_rise)
        begin
          nxt_state = FSCR_RUN; // [R13]
        end
      end
      FSCR_RUN:
      begin
        if (!speaker_shutdown_n)
        begin
          nxt_state = FSCR_SHUT;
        end
        else if (nxt_ocf || nxt_dcf || nxt_otf)
        begin
          nxt_state = FSCR_HALT; // [R04] [R05] [R06]
        end
      end
      FSCR_HALT:
      begin
        if (!speaker_shutdown_n)
        begin
          nxt_state = FSCR_SHUT;
        end
      end
      default: nxt_state = FSCR_SHUT;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= FSCR_SHUT;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // audio passes only while running with valid clocks
  assign amp_run = (state_ff == FSCR_RUN) && !clkf_ff; // [R03]
  assign sample_out = amp_run ? clipped : 20'sh00000;
  assign rdata = rdata_ff;
  assign clock_fault_flag = clkf_ff;
  assign overcurrent_fault_flag = ocf_ff;
  assign dc_offset_fault_flag = dcf_ff;
  assign overtemp_fault_flag = otf_ff;
endmodule : fscr_regs

// [test/fscr_regs_properties.sv]
module fscr_regs_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire fscr_pkg::fscr_req_t req,
  input wire logic [7:0] rdata,
  input wire fscr_pkg::fscr_sense_t sense,
  input wire logic speaker_shutdown_n,
  input wire logic signed [19:0] sample_out,
  input wire logic amp_run,
  input wire logic clock_fault_flag,
  input wire logic overcurrent_fault_flag,
  input wire logic dc_offset_fault_flag,
  input wire logic overtemp_fault_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_clk_set; sense.clock_bad |=> clock_fault_flag; endproperty
  a_clk_set: assert property (p_clk_set) else $error("clock flag missed");
  property p_clk_clr; !sense.clock_bad |=> !clock_fault_flag; endproperty
  a_clk_clr: assert property (p_clk_clr) else $error("clock flag stuck");
  property p_oc_hold; speaker_shutdown_n[*4] ##0 overcurrent_fault_flag |=> overcurrent_fault_flag;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("oc flag lost");
  property p_dc_hold; speaker_shutdown_n[*4] ##0 dc_offset_fault_flag |=> dc_offset_fault_flag;
  endproperty
  a_dc_hold: assert property (p_dc_hold) else $error("dc flag lost");
  property p_ot_hold; speaker_shutdown_n[*4] ##0 overtemp_fault_flag |=> overtemp_fault_flag;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("ot flag lost");
  property p_halt; overcurrent_fault_flag || dc_offset_fault_flag || overtemp_fault_flag
    |-> !amp_run; endproperty
  a_halt: assert property (p_halt) else $error("run with fault");
  property p_mute; !amp_run |-> sample_out == 20'h00000; endproperty
  a_mute: assert property (p_mute) else $error("output while halted");
  property p_rd; req.rd_en && req.addr == 8'h08 |=> rdata[7:6] == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("reserved bits set");
  c_oc: cover property (overcurrent_fault_flag);
  c_clk: cover property (clock_fault_flag);
  c_run: cover property (amp_run);
endmodule : fscr_regs_properties

bind fscr_regs fscr_regs_properties u_fscr_regs_properties (.*);

// [test/fscr_host.sv]
module fscr_host (
  input wire logic clk_sys,
  output fscr_pkg::fscr_req_t req,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // callers keep 0x11 bits 1:0 zero and stay off 0x09-0x0F
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    req = '0;
    d = rdata;
  endtask : rd
endmodule : fscr_host

// [test/fscr_regs_bench.sv]
module fscr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sd_n = 1'b1;
  fscr_pkg::fscr_req_t req;
  fscr_pkg::fscr_sense_t sense = '0;
  logic signed [19:0] smp = 20'h80000;
  logic signed [19:0] smp_out;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic run;
  logic [3:0] flg;
  logic [15:0] lim [4] = '{16'h0100, 16'h00C0, 16'h0080, 16'h0040};
  int n_errors = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  fscr_host u_fscr_host (.clk_sys(clk_sys), .req(req), .rdata(rdata));
  fscr_regs u_fscr_regs (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
    .sense(sense), .overcurrent_nominal(16'h0100), .speaker_shutdown_n(sd_n),
    .sample_in(smp), .sample_out(smp_out), .amp_run(run), .clock_fault_flag(flg[3]),
    .overcurrent_fault_flag(flg[2]), .dc_offset_fault_flag(flg[1]),
    .overtemp_fault_flag(flg[0]));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_fscr_host.rd(a, rv);
    chk({12'h000, rv}, {12'h000, e});
  endtask : rchk
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic toggle();
    sd_n = 1'b0;
    step(2);
    sd_n = 1'b1;
    step(3);
  endtask : toggle
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  initial
  begin
    step(5);
    rst = 1'b0;
    step(2);
    rchk(8'h08, 8'h00);
    rchk(8'h10, 8'hFF);
    rchk(8'h11, 8'hFC);
    u_fscr_host.wr(8'h11, 8'hA8);
    u_fscr_host.wr(8'h10, 8'h5A);
    rchk(8'h11, 8'hA8);
    rchk(8'h10, 8'h5A);
    chk(smp_out, 20'h80001);
    $display("registers and clip done");
    for (int c = 0; c < 4; c++)
    begin
      u_fscr_host.wr(8'h08, {2'h0, c[1:0], 4'hF});
      rchk(8'h08, {2'h0, c[1:0], 4'h0});
      sense.current = lim[c];
      step(2);
      chk({flg[2], run}, 20'h1);
      sense.current = lim[c] + 16'h0001;
      step(2);
      sense.current = 16'h0000;
      step(2);
      chk({flg[2], run}, 20'h2);
      toggle();
      chk({flg[2], run}, 20'h1);
    end
    $display("overcurrent done");
    sense = '{1'b1, 1'b1, 1'b1, 16'h0000};
    step(2);
    sense = '0;
    step(2);
    chk({flg, run}, 20'h06);
    rchk(8'h08, 8'h33);
    toggle();
    chk({flg, run}, 20'h01);
    sense.clock_bad = 1'b1;
    step(2);
    chk({flg, run}, 20'h10);
    sense.clock_bad = 1'b0;
    step(2);
    chk({flg, run}, 20'h01);
    $display("faults done");
    final_report();
  end
endmodule : fscr_regs_bench
